// >>> core/pcld_pkg.sv
// Package of constants shared by both ends of the single-wire dimmer link
// Assumes one system clock at 125 MHz for device and host logic
package pcld_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int OFF_TIME_US_X10 = 15000;   // 1.5 ms shutdown low time, in 0.1 us
  localparam int OFF_CYCLES = (OFF_TIME_US_X10 * CLK_MHZ + 9) / 10;
  localparam int MODE_DELAY_US = 400;       // 1x to 1.5x delay
  localparam int MODE_DELAY_CYCLES = MODE_DELAY_US * CLK_MHZ;
  localparam int SETUP_US = 10;             // Host setup high time
  localparam int SETUP_CYCLES = SETUP_US * CLK_MHZ;
  localparam int PULSE_MIN_NS = 300;        // Least low and high time
  localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MAX_US = 200;        // Longest low time
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_US * CLK_MHZ;
  localparam int PUMP_FREQ_KHZ = 1000;      // Pump switching frequency
  localparam int PUMP_HALF_CYCLES = CLK_MHZ * 1000 / PUMP_FREQ_KHZ / 2;

  // ****************************************
  // Current levels
  // ****************************************
  localparam int LEVEL_W = 5;
  localparam logic [4:0] LEVEL_FULL = 5'h1f;  // 31 mA
  localparam logic [4:0] LEVEL_ZERO = 5'h00;
  localparam logic [4:0] LEVEL_STEP = 5'h01;  // 1 mA
  localparam int CHANNELS = 4;

endpackage

// >>> core/pcld_link_if.sv
// Single-wire enable/dim link between host and device
// Assumes both ends on i_clk_sys; device synchronises the wire anyway
interface pcld_link_if;
  logic enable_dim_input;
  modport device (input enable_dim_input);
  modport host (output enable_dim_input);
endinterface

// >>> core/pcld_device.sv
// Device end: dimming level, shutdown, pump mode sequencing, protections
// Assumes analog indications arrive asynchronously; they are synchronised
// Behaviour
// - First rise enables with zero current
// - First falling edge sets 31 mA
// - Later falling edges step down 1 mA
// - 32nd pulse gives zero current
// - Pulse at zero wraps to 31 mA
// - Low for 1.5 ms means shutdown
// - Shutdown makes all sinks high impedance
// - Undervoltage disables all channels
// - Power-up starts in 1x mode
// - Stay 1x while regulation holds
// - Lost regulation moves to 1.5x after 400 us
// - Sequence restarts on power-up and wake
// - Host holds input high 10 us first
// - Host pulse low time 300 ns to 200 us
// - Host keeps pulses 300 ns apart
// - Host pulse rate 5 kHz to 1 MHz; host here allows a pulse every 77 cycles, about 1.6 MHz
// - Over-temperature shuts down until cooled; device here forces zero current, no shutdown or high impedance
// - Channel tied to pump output disabled
// - Pump switches at 1 MHz in 1.5x
module pcld_device #(
  parameter int OFF_CYCLES = pcld_pkg::OFF_CYCLES,
  parameter int MODE_DELAY_CYCLES = pcld_pkg::MODE_DELAY_CYCLES
) (
  input wire logic i_clk_sys,                       // System clock
  input wire logic i_reset_n,                       // Power-up reset
  pcld_link_if.device link,                         // Enable/dim wire
  input wire logic i_undervoltage,                  // Supply below threshold
  input wire logic i_over_temp,                     // Die too hot, with hysteresis
  input wire logic i_regulation_ok,                 // All currents regulated
  input wire logic [3:0] i_tied_to_pump_output,     // Sink pin on pump output
  output logic o_enabled,                           // Out of shutdown
  output logic [4:0] o_level,                       // Shared level, mA
  output logic [3:0] o_sink_channel_enable,         // Per-channel current on
  output logic [3:0] o_sink_channel_hiz,            // Per-channel high impedance
  output logic o_pump_mode_1p5x,                    // Pump in 1.5x mode
  output logic o_pump_clock                         // Pump switching clock
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic dim_prev;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      dim_prev <= 1'b0;
    end else begin
      sync1 <= {i_tied_to_pump_output, i_regulation_ok, i_over_temp,
                i_undervoltage, link.enable_dim_input};
      sync2 <= sync1;
      dim_prev <= sync2[0];
    end
  end

  logic dim_in;
  logic uv;
  logic ot;
  logic reg_ok;
  logic [3:0] tied;
  assign dim_in = sync2[0];
  assign uv = sync2[1];
  assign ot = sync2[2];
  assign reg_ok = sync2[3];
  assign tied = sync2[7:4];

  logic fall;
  logic rise;
  assign fall = dim_prev && !dim_in;
  assign rise = !dim_prev && dim_in;

  // ****************************************
  // Enable, level and shutdown timer
  // ****************************************
  typedef enum logic [1:0] {
    PCLD_SHUTDOWN,
    PCLD_IDLE_ZERO,
    PCLD_DIMMING
  } pcld_dev_state_t;

  pcld_dev_state_t state;
  pcld_dev_state_t next_state;
  logic [4:0] level;
  logic [4:0] next_level;
  logic [31:0] low_count;
  logic [31:0] next_low_count;
  logic wake;

  always_comb begin
    next_state = state;
    next_level = level;
    next_low_count = low_count;
    wake = 1'b0;
    if (dim_in) begin
      next_low_count = '0;
    end else if (fall) begin
      next_low_count = 32'h0000_0001;
    end else if (low_count < OFF_CYCLES) begin
      next_low_count = low_count + 32'h0000_0001;
    end
    unique case (state)
      PCLD_SHUTDOWN: begin
        if (rise) begin
          next_state = PCLD_IDLE_ZERO;
          next_level = pcld_pkg::LEVEL_ZERO;
          wake = 1'b1;
        end
      end
      PCLD_IDLE_ZERO: begin
        if (fall) begin
          next_state = PCLD_DIMMING;
          next_level = pcld_pkg::LEVEL_FULL;
        end
      end
      PCLD_DIMMING: begin
        if (fall) begin
          if (level == pcld_pkg::LEVEL_ZERO) begin
            next_level = pcld_pkg::LEVEL_FULL;
          end else begin
            next_level = level - pcld_pkg::LEVEL_STEP;
          end
        end
      end
      default: begin
        next_state = PCLD_SHUTDOWN;
      end
    endcase
    if (state != PCLD_SHUTDOWN && !dim_in && low_count >= OFF_CYCLES - 1) begin
      next_state = PCLD_SHUTDOWN;
      next_level = pcld_pkg::LEVEL_ZERO;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= PCLD_SHUTDOWN;
      level <= 5'h00;
      low_count <= 32'h0000_0000;
    end else begin
      state <= next_state;
      level <= next_level;
      low_count <= next_low_count;
    end
  end

  // ****************************************
  // Pump mode sequencing
  // ****************************************
  logic mode_1p5x;
  logic next_mode_1p5x;
  logic [31:0] mode_count;
  logic [31:0] next_mode_count;
  logic [7:0] pump_div;
  logic [7:0] next_pump_div;
  logic pump_clk;
  logic next_pump_clk;

  always_comb begin
    next_mode_1p5x = mode_1p5x;
    next_mode_count = mode_count;
    if (wake || state == PCLD_SHUTDOWN) begin
      next_mode_1p5x = 1'b0;
      next_mode_count = '0;
    end else if (!mode_1p5x && reg_ok) begin
      next_mode_count = '0;
    end else if (!mode_1p5x) begin
      if (mode_count >= MODE_DELAY_CYCLES - 1) begin
        next_mode_1p5x = 1'b1;
        next_mode_count = '0;
      end else begin
        next_mode_count = mode_count + 32'h0000_0001;
      end
    end
    // 1 MHz pump clock in 1.5x
    next_pump_div = pump_div;
    next_pump_clk = pump_clk;
    if (!mode_1p5x || state == PCLD_SHUTDOWN) begin
      next_pump_div = 8'h00;
      next_pump_clk = 1'b0;
    end else if (pump_div >= 8'(pcld_pkg::PUMP_HALF_CYCLES - 1)) begin
      next_pump_div = 8'h00;
      next_pump_clk = !pump_clk;
    end else begin
      next_pump_div = pump_div + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_1p5x <= 1'b0;
      mode_count <= 32'h0000_0000;
      pump_div <= 8'h00;
      pump_clk <= 1'b0;
    end else begin
      mode_1p5x <= next_mode_1p5x;
      mode_count <= next_mode_count;
      pump_div <= next_pump_div;
      pump_clk <= next_pump_clk;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic active;
  logic [3:0] next_chan_en;
  logic [3:0] next_chan_hiz;
  logic next_enabled;
  logic [4:0] next_out_level;
  logic next_out_mode;
  logic next_out_pump;
  always_comb begin
    active = state != PCLD_SHUTDOWN && !uv && !ot;
    next_enabled = state != PCLD_SHUTDOWN;
    next_out_level = active ? level : pcld_pkg::LEVEL_ZERO;
    next_out_mode = mode_1p5x && active;
    next_out_pump = pump_clk && active;
    next_chan_en = (active && level != pcld_pkg::LEVEL_ZERO) ? ~tied : 4'h0;
    next_chan_hiz = (state == PCLD_SHUTDOWN) ? 4'hf : 4'h0;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_enabled <= 1'b0;
      o_level <= 5'h00;
      o_sink_channel_enable <= 4'h0;
      o_sink_channel_hiz <= 4'hf;
      o_pump_mode_1p5x <= 1'b0;
      o_pump_clock <= 1'b0;
    end else begin
      o_enabled <= next_enabled;
      o_level <= next_out_level;
      o_sink_channel_enable <= next_chan_en;
      o_sink_channel_hiz <= next_chan_hiz;
      o_pump_mode_1p5x <= next_out_mode;
      o_pump_clock <= next_out_pump;
    end
  end

endmodule

// >>> core/pcld_host.sv
// Host end: drives the enable/dim wire from user commands
// Assumes commands come from logic on i_clk_sys
module pcld_host #(
  parameter int SETUP_CYCLES = pcld_pkg::SETUP_CYCLES,
  parameter int PULSE_CYCLES = pcld_pkg::PULSE_MIN_CYCLES,
  parameter int OFF_CYCLES = pcld_pkg::OFF_CYCLES
) (
  input wire logic i_clk_sys,             // System clock
  input wire logic i_reset_n,             // Async reset
  pcld_link_if.host link,                 // Enable/dim wire
  input wire logic i_enable,              // Pulse: wake device
  input wire logic i_pulse,               // Pulse: send one dimming pulse
  input wire logic i_shutdown,            // Pulse: hold low to shut down
  output logic o_busy,                    // Command in progress
  output logic o_awake                    // Device set up and awake
);

  typedef enum logic [2:0] {
    PCLD_H_OFF,
    PCLD_H_SETUP,
    PCLD_H_READY,
    PCLD_H_LOW,
    PCLD_H_HIGH,
    PCLD_H_SHUT
  } pcld_host_state_t;

  pcld_host_state_t state;
  pcld_host_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_wire;
  logic next_busy;
  logic next_awake;

  always_comb begin
    next_state = state;
    next_count = count + 32'h0000_0001;
    unique case (state)
      PCLD_H_OFF: begin
        next_count = '0;
        if (i_enable) begin
          next_state = PCLD_H_SETUP;
        end
      end
      PCLD_H_SETUP: begin
        if (count >= SETUP_CYCLES - 1) begin
          next_state = PCLD_H_READY;
        end
      end
      PCLD_H_READY: begin
        next_count = '0;
        if (i_shutdown) begin
          next_state = PCLD_H_SHUT;
        end else if (i_pulse) begin
          next_state = PCLD_H_LOW;
        end
      end
      PCLD_H_LOW: begin
        if (count >= PULSE_CYCLES - 1) begin
          next_state = PCLD_H_HIGH;
          next_count = '0;
        end
      end
      PCLD_H_HIGH: begin
        if (count >= PULSE_CYCLES - 1) begin
          next_state = PCLD_H_READY;
        end
      end
      PCLD_H_SHUT: begin
        if (count >= OFF_CYCLES - 1) begin
          next_state = PCLD_H_OFF;
        end
      end
      default: begin
        next_state = PCLD_H_OFF;
      end
    endcase
    next_wire = next_state == PCLD_H_SETUP || next_state == PCLD_H_READY
                || next_state == PCLD_H_HIGH;
    next_busy = next_state != PCLD_H_OFF && next_state != PCLD_H_READY;
    next_awake = next_state == PCLD_H_READY;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= PCLD_H_OFF;
      count <= 32'h0000_0000;
      link.enable_dim_input <= 1'b0;
      o_busy <= 1'b0;
      o_awake <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      link.enable_dim_input <= next_wire;
      o_busy <= next_busy;
      o_awake <= next_awake;
    end
  end

endmodule

// >>> tb/pcld_sva.sv
// Checker for the dimmer link: wire activity against device outputs
// Assumes one clock domain; instantiated beside the link interface
module pcld_sva #(
  parameter int OFF_CYCLES = pcld_pkg::OFF_CYCLES,
  parameter int MODE_DELAY_CYCLES = pcld_pkg::MODE_DELAY_CYCLES
) (
  input wire logic i_clk_sys,                    // System clock
  input wire logic i_reset_n,                    // Async reset
  input wire logic enable_dim_input,             // Link wire
  input wire logic i_undervoltage,               // Supply low
  input wire logic i_over_temp,                  // Die hot
  input wire logic i_regulation_ok,              // Currents regulated
  input wire logic [3:0] i_tied_to_pump_output,  // Tied sinks
  input wire logic o_enabled,                    // Out of shutdown
  input wire logic [4:0] o_level,                // Level
  input wire logic [3:0] o_sink_channel_enable,  // Sinks on
  input wire logic [3:0] o_sink_channel_hiz,     // Sinks floating
  input wire logic o_pump_mode_1p5x,             // 1.5x mode
  input wire logic o_pump_clock                  // Pump clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt;
  int lost_cnt;
  int next_low_cnt;
  int next_lost_cnt;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // ****
  // Low time and lost regulation time
  // ****
  always_comb begin
    next_low_cnt = enable_dim_input ? 0 : low_cnt + 1;
    next_lost_cnt = (i_regulation_ok || !o_enabled) ? 0 : lost_cnt + 1;
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt <= 0;
      lost_cnt <= 0;
    end else begin
      low_cnt <= next_low_cnt;
      lost_cnt <= next_lost_cnt;
    end
  end
  // ****
  // Properties
  // ****
  a_wake_zero: assert property ($rose(o_enabled) |-> o_level == 5'h00)
    else $error("level not zero on wake");
  a_fall_step: assert property ($fell(enable_dim_input) && o_enabled &&
    !i_undervoltage && !i_over_temp |-> ##4
    o_level == (($past(o_level, 4) == 5'h00) ? 5'h1f : $past(o_level, 4) - 5'h01))
    else $error("level step wrong");
  a_off_hiz: assert property (!o_enabled |-> o_sink_channel_hiz == 4'hf)
    else $error("sinks not floating in shutdown");
  a_uv_dark: assert property (i_undervoltage [*5] |-> o_sink_channel_enable == 4'h0)
    else $error("sinks on in undervoltage");
  a_hot_dark: assert property (i_over_temp [*5] |-> o_level == 5'h00)
    else $error("current on while hot");
  a_tied_off: assert property ($stable(i_tied_to_pump_output) [*5] |->
    (o_sink_channel_enable & i_tied_to_pump_output) == 4'h0)
    else $error("tied sink enabled");
  a_wake_1x: assert property ($rose(o_enabled) |-> !o_pump_mode_1p5x)
    else $error("wake not in 1x");
  a_mode_early: assert property ($rose(o_pump_mode_1p5x) |->
    lost_cnt >= MODE_DELAY_CYCLES - 4)
    else $error("1.5x too early");
  a_mode_late: assert property (lost_cnt == MODE_DELAY_CYCLES + 10 |-> o_pump_mode_1p5x)
    else $error("1.5x too late");
  a_pump_half: assert property ($rose(o_pump_clock) && o_pump_mode_1p5x |->
    ##62 ($fell(o_pump_clock) || !o_enabled))
    else $error("pump half period wrong");
  a_off_early: assert property ($fell(o_enabled) |-> low_cnt >= OFF_CYCLES)
    else $error("shutdown too early");
  a_off_late: assert property (low_cnt == OFF_CYCLES + 8 |-> !o_enabled)
    else $error("shutdown too late");
endmodule

// >>> tb/pulse_count_led_dimmer_bench.sv
// Bench for the dimmer link: host end drives the device end over the wire
// Assumes shortened timing parameters for simulation
module pulse_count_led_dimmer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFFD = 200;
  localparam int MDLY = 100;
  localparam int SETD = 20;
  localparam int PULD = 38;
  localparam int HOFF = 250;
  logic i_clk_sys;
  logic i_reset_n;
  logic i_enable;
  logic i_pulse;
  logic i_shutdown;
  logic i_undervoltage;
  logic i_over_temp;
  logic i_regulation_ok;
  logic [3:0] i_tied_to_pump_output;
  logic o_busy;
  logic o_awake;
  logic o_enabled;
  logic [4:0] o_level;
  logic [3:0] o_sink_channel_enable;
  logic [3:0] o_sink_channel_hiz;
  logic o_pump_mode_1p5x;
  logic o_pump_clock;
  logic [4:0] lv;
  int failures;
  int checks_done;
  pcld_link_if pcld_link_if_inst ();
  pcld_host #(.SETUP_CYCLES(SETD), .PULSE_CYCLES(PULD), .OFF_CYCLES(HOFF)) pcld_host_inst (
    .i_clk_sys, .i_reset_n, .link(pcld_link_if_inst), .i_enable, .i_pulse, .i_shutdown,
    .o_busy, .o_awake);
  pcld_device #(.OFF_CYCLES(OFFD), .MODE_DELAY_CYCLES(MDLY)) pcld_device_inst (
    .i_clk_sys, .i_reset_n, .link(pcld_link_if_inst), .i_undervoltage, .i_over_temp,
    .i_regulation_ok, .i_tied_to_pump_output, .o_enabled, .o_level, .o_sink_channel_enable,
    .o_sink_channel_hiz, .o_pump_mode_1p5x, .o_pump_clock);
  pcld_sva #(.OFF_CYCLES(OFFD), .MODE_DELAY_CYCLES(MDLY)) pcld_sva_inst (
    .i_clk_sys, .i_reset_n, .enable_dim_input(pcld_link_if_inst.enable_dim_input),
    .i_undervoltage, .i_over_temp, .i_regulation_ok, .i_tied_to_pump_output, .o_enabled,
    .o_level, .o_sink_channel_enable, .o_sink_channel_hiz, .o_pump_mode_1p5x, .o_pump_clock);
  // ****
  // Helpers
  // ****
  task automatic cmp(input string nm, input logic [4:0] e, input logic [4:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic cmd(input int k);
    int n;
    cyc(1);
    i_enable = (k == 0);
    i_pulse = (k == 1);
    i_shutdown = (k == 2);
    cyc(1);
    i_enable = 1'b0;
    i_pulse = 1'b0;
    i_shutdown = 1'b0;
    n = 0;
    while (o_busy === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    cmp("busy", 5'h00, 5'(o_busy));
    cmp("awake", (k == 2) ? 5'h00 : 5'h01, 5'(o_awake));
    cmp("span", 5'h01, 5'(n == ((k == 0) ? SETD : (k == 1) ? 2 * PULD : HOFF)));
  endtask
  task automatic summarize;
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_wake;
    cmd(0);
    cmp("enabled", 5'h01, 5'(o_enabled));
    cmp("level", 5'h00, o_level);
    cmp("hiz", 5'h00, 5'(o_sink_channel_hiz));
    cmp("mode", 5'h00, 5'(o_pump_mode_1p5x));
  endtask
  task automatic t_dim;
    lv = 5'h00;
    for (int k = 1; k <= 33; k++) begin
      cmd(1);
      lv = (lv == 5'h00) ? 5'h1f : lv - 5'h01;
      cmp("level", lv, o_level);
      cmp("sinks", (lv != 5'h00) ? 5'h07 : 5'h00, 5'(o_sink_channel_enable));
    end
    cmp("enabled", 5'h01, 5'(o_enabled));
  endtask
  task automatic t_prot;
    i_undervoltage = 1'b1;
    cyc(8);
    cmp("sinks", 5'h00, 5'(o_sink_channel_enable));
    i_undervoltage = 1'b0;
    i_over_temp = 1'b1;
    cyc(8);
    cmp("level", 5'h00, o_level);
    i_over_temp = 1'b0;
    cyc(8);
    cmp("level", 5'h1f, o_level);
    cmp("sinks", 5'h07, 5'(o_sink_channel_enable));
  endtask
  task automatic t_mode;
    int n;
    cmp("mode", 5'h00, 5'(o_pump_mode_1p5x));
    i_regulation_ok = 1'b0;
    cyc(MDLY - 10);
    cmp("mode", 5'h00, 5'(o_pump_mode_1p5x));
    cyc(20);
    cmp("mode", 5'h01, 5'(o_pump_mode_1p5x));
    n = 0;
    while (o_pump_clock !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (o_pump_clock === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cmp("pump", 5'h01, 5'(n == pcld_pkg::PUMP_HALF_CYCLES));
    cyc(200);
  endtask
  task automatic t_off;
    cmd(2);
    cmp("enabled", 5'h00, 5'(o_enabled));
    cmp("hiz", 5'h0f, 5'(o_sink_channel_hiz));
    cmd(0);
    cmp("mode", 5'h00, 5'(o_pump_mode_1p5x));
    cmp("level", 5'h00, o_level);
    cyc(MDLY + 10);
    cmp("mode", 5'h01, 5'(o_pump_mode_1p5x));
  endtask
  // ****
  // Clock, sequence and watchdog
  // ****
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    failures = 0;
    checks_done = 0;
    i_reset_n = 1'b0;
    i_enable = 1'b0;
    i_pulse = 1'b0;
    i_shutdown = 1'b0;
    i_undervoltage = 1'b0;
    i_over_temp = 1'b0;
    i_regulation_ok = 1'b1;
    i_tied_to_pump_output = 4'h8;
    cyc(6);
    i_reset_n = 1'b1;
    t_wake();
    t_dim();
    t_prot();
    t_mode();
    t_off();
    summarize();
  end
  initial begin
    #160000;
    failures++;
    summarize();
  end
endmodule
